// file: logic/tpio_top.sv
// timer/counter with prescaler, period match, postscaler, toggle output and flag
// assumes REF_CLK_I is the instruction clock; oscillator and pin sources are foreign
//
// Overview of operation
// - output divider offers sixteen ratios, one to sixteen
// - divider hidden, cleared by low, control-a or control-b write
// - sleep halts synchronised mode, unsynchronised keeps counting
// - match on period equal or 16-bit wrap
// - flag set every divider-select plus one events
// - enabled flag interrupts and may wake device
// - output offered to pins and other peripherals
// - control-a bit five shows output level, read-only
// - pulse spans one tick, output toggles per pulse
// - control-a bit seven enables, zero stops everything
// - control-a bit four selects wide counting
// - divider ratio equals field value plus one
// - control-b top bits choose count clock
// - control-b bit four only keeps counting in sleep; sources are always synchronised
// - prescale ratio is two to field power
// - control-a bit six reads zero always
// - narrow match clears low, reloads period buffer
// - wide high byte buffered via low access
// - both scalers cleared on low/control writes, reset
`timescale 1ns/1ps
`include "tpio_map.svh"
module tpio_top (
  input  wire logic       REF_CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic [3:0] ADDR_I,
  input  wire logic [7:0] WR_DATA_I,
  input  wire logic       WR_EN_I,
  input  wire logic       RD_EN_I,
  output logic      [7:0] RD_DATA_O,
  input  wire logic       COUNT_PIN_I,
  input  wire logic       LOGIC_CELL_ONE_I,
  input  wire logic       MEDIUM_INTERNAL_OSC_I,
  input  wire logic       LOW_INTERNAL_OSC_I,
  input  wire logic       HIGH_INTERNAL_OSC_I,
  input  wire logic       SLEEP_I,
  output logic            TIMER_OUT_O,
  output logic            DIVIDED_MATCH_PULSE_O,
  output logic            TIMER_IRQ_FLAG_O,
  output logic            TIMER_IRQ_O,
  output logic            WAKE_O
);

  logic                        rst_meta;
  logic                        rst_n;
  logic [`TPIO_NUM_SRC-1:0]    src_raw;
  logic [`TPIO_NUM_SRC-1:0]    src_meta;
  logic [`TPIO_NUM_SRC-1:0]    src_sync;
  logic                        sel_level;
  logic                        sel_prev;
  logic                        src_evt;
  logic                        run;
  logic [14:0]                 presc_cnt;
  logic [14:0]                 presc_mask;
  logic                        tick;
  logic [7:0]                  ctrl_a;
  logic [7:0]                  ctrl_b;
  logic [7:0]                  cnt_low;
  logic [7:0]                  cnt_high;
  logic [7:0]                  high_buf;
  logic [7:0]                  period_buf;
  logic                        match;
  logic [3:0]                  post_cnt;
  logic                        div_evt;
  logic                        div_pulse;
  logic                        out_level;
  logic                        irq_flag;
  logic                        irq_en;
  logic                        wr_a;
  logic                        wr_b;
  logic                        wr_low;
  logic                        wr_high;
  logic                        wr_irq;
  logic                        rd_low;
  logic                        clr_scalers;
  logic                        wide;
  logic                        en;
  logic [3:0]                  div_sel;
  tpio_pkg::tpio_src_t         src_sel;

  // reset release through two flops
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // bus strobe decode
  assign wr_a    = WR_EN_I && (ADDR_I == `TPIO_OFS_CTRL_A);
  assign wr_b    = WR_EN_I && (ADDR_I == `TPIO_OFS_CTRL_B);
  assign wr_low  = WR_EN_I && (ADDR_I == `TPIO_OFS_COUNT_LOW);
  assign wr_high = WR_EN_I && (ADDR_I == `TPIO_OFS_COUNT_HIGH);
  assign wr_irq  = WR_EN_I && (ADDR_I == `TPIO_OFS_IRQ);
  assign rd_low  = RD_EN_I && (ADDR_I == `TPIO_OFS_COUNT_LOW);
  assign clr_scalers = wr_low || wr_a || wr_b;

  // control field aliases
  assign en      = ctrl_a[`TPIO_A_EN];
  assign wide    = ctrl_a[`TPIO_A_WIDE];
  assign div_sel = ctrl_a[`TPIO_A_DIV_HI:0];
  assign src_sel = tpio_pkg::tpio_src_t'(ctrl_b[`TPIO_B_CS_HI:`TPIO_B_CS_LO]);

  // control registers; bit 5 and bit 6 of control-a are never stored
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a <= `TPIO_RST_CTRL;
      ctrl_b <= `TPIO_RST_CTRL;
    end else begin
      if (wr_a) begin
        ctrl_a <= {WR_DATA_I[7], 2'b00, WR_DATA_I[4:0]};
      end
      if (wr_b) begin
        ctrl_b <= WR_DATA_I;
      end
    end
  end

  // foreign clock sources: pin, logic cell and the three oscillators
  assign src_raw = {LOGIC_CELL_ONE_I, MEDIUM_INTERNAL_OSC_I, LOW_INTERNAL_OSC_I,
                    HIGH_INTERNAL_OSC_I, COUNT_PIN_I};

  // two-flop synchroniser per source
  generate
    for (genvar g = 0; g < `TPIO_NUM_SRC; g++) begin : g_sync
      always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
          src_meta[g] <= 1'b0;
          src_sync[g] <= 1'b0;
        end else begin
          src_meta[g] <= src_raw[g];
          src_sync[g] <= src_meta[g];
        end
      end
    end
  endgenerate

  // count clock selection from synchronised copies
  always_comb begin
    sel_level = 1'b0;
    unique case (src_sel)
      tpio_pkg::SRC_PIN_TRUE:   sel_level = src_sync[0];
      tpio_pkg::SRC_PIN_INV:    sel_level = ~src_sync[0];
      tpio_pkg::SRC_INSTR:      sel_level = 1'b0;
      tpio_pkg::SRC_HIGH_OSC:   sel_level = src_sync[1];
      tpio_pkg::SRC_LOW_OSC:    sel_level = src_sync[2];
      tpio_pkg::SRC_MED_OSC:    sel_level = src_sync[3];
      tpio_pkg::SRC_RESERVED:   sel_level = 1'b0;
      tpio_pkg::SRC_LOGIC_CELL: sel_level = src_sync[4];
    endcase
  end

  // rising edge detector on the selected level
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev <= 1'b0;
    end else begin
      sel_prev <= sel_level;
    end
  end

  // instruction clock counts every cycle, others on a rising edge
  assign src_evt = (src_sel == tpio_pkg::SRC_INSTR) || (sel_level && !sel_prev);
  // disabled or synchronised in sleep: nothing advances
  assign run = en && !(SLEEP_I && !ctrl_b[`TPIO_B_UNSYNC]);

  // prescaler: tick once every 2^ps source events
  assign presc_mask = 15'((16'h0001 << ctrl_b[`TPIO_B_PS_HI:0]) - 16'h0001);
  assign tick = run && src_evt && ((presc_cnt & presc_mask) == presc_mask);

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      presc_cnt <= 15'h0000;
    end else if (clr_scalers) begin
      presc_cnt <= 15'h0000;
    end else if (run && src_evt) begin
      presc_cnt <= presc_cnt + 15'h0001;
    end
  end

  // match: period equal in narrow mode, full wrap in wide mode
  assign match = tick && (wide ? ({cnt_high, cnt_low} == `TPIO_WIDE_MAX)
                               : (cnt_low == period_buf));

  // count registers; a low write wins over a count tick
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cnt_low  <= `TPIO_RST_LOW;
      cnt_high <= `TPIO_RST_LOW;
    end else if (wr_low) begin
      cnt_low <= WR_DATA_I;
      if (wide) begin
        cnt_high <= high_buf;
      end
    end else if (tick) begin
      if (wide) begin
        {cnt_high, cnt_low} <= {cnt_high, cnt_low} + 16'h0001;
      end else if (match) begin
        cnt_low <= 8'h00;
      end else begin
        cnt_low <= cnt_low + 8'h01;
      end
    end
  end

  // high byte holding register and period buffer
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      high_buf   <= `TPIO_RST_HIGH;
      period_buf <= `TPIO_RST_HIGH;
    end else begin
      if (wr_high) begin
        high_buf <= WR_DATA_I;
      end else if (rd_low && wide) begin
        high_buf <= cnt_high;
      end
      if (match && !wide && !wr_low) begin
        period_buf <= high_buf;
      end
    end
  end

  // postscaler: one divided event per div_sel+1 matches
  assign div_evt = match && (post_cnt == div_sel) && !wr_low;

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      post_cnt <= 4'h0;
    end else if (clr_scalers) begin
      post_cnt <= 4'h0;
    end else if (match) begin
      post_cnt <= (post_cnt == div_sel) ? 4'h0 : post_cnt + 4'h1;
    end
  end

  // divided pulse held for one tick period, output toggles per event
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      div_pulse <= 1'b0;
      out_level <= 1'b0;
    end else begin
      if (clr_scalers || !en) begin
        div_pulse <= 1'b0;
      end else if (tick) begin
        div_pulse <= div_evt;
      end
      if (div_evt) begin
        out_level <= ~out_level;
      end
    end
  end

  // sticky flag, set wins over a software clear
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag <= 1'b0;
      irq_en   <= 1'b0;
    end else begin
      if (div_evt) begin
        irq_flag <= 1'b1;
      end else if (wr_irq) begin
        irq_flag <= WR_DATA_I[`TPIO_I_FLAG];
      end
      if (wr_irq) begin
        irq_en <= WR_DATA_I[`TPIO_I_EN];
      end
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      RD_DATA_O <= 8'h00;
    end else if (RD_EN_I) begin
      unique case (ADDR_I)
        `TPIO_OFS_CTRL_A:     RD_DATA_O <= {en, 1'b0, out_level, ctrl_a[4:0]};
        `TPIO_OFS_CTRL_B:     RD_DATA_O <= ctrl_b;
        `TPIO_OFS_COUNT_LOW:  RD_DATA_O <= cnt_low;
        `TPIO_OFS_COUNT_HIGH: RD_DATA_O <= high_buf;
        `TPIO_OFS_IRQ:        RD_DATA_O <= {6'h00, irq_en, irq_flag};
        default:              RD_DATA_O <= 8'h00; // unmapped
      endcase
    end else begin
      RD_DATA_O <= 8'h00;
    end
  end

  // outputs to pins, peripherals and the processor
  assign TIMER_OUT_O           = out_level;
  assign DIVIDED_MATCH_PULSE_O = div_pulse;
  assign TIMER_IRQ_FLAG_O      = irq_flag;
  assign TIMER_IRQ_O           = irq_flag && irq_en;
  assign WAKE_O                = irq_flag && irq_en && SLEEP_I;

  // checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!rst_n);

  property p_flag_set;
    div_evt |=> irq_flag && TIMER_IRQ_FLAG_O;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on divided event");

  property p_toggle;
    div_evt |=> TIMER_OUT_O != $past(TIMER_OUT_O);
  endproperty
  a_toggle: assert property (p_toggle) else $error("output did not toggle");

  property p_bit6;
    RD_EN_I && ADDR_I == `TPIO_OFS_CTRL_A |=> RD_DATA_O[6] == 1'b0;
  endproperty
  a_bit6: assert property (p_bit6) else $error("control-a bit 6 read nonzero");

  property p_out_bit;
    RD_EN_I && ADDR_I == `TPIO_OFS_CTRL_A |=> RD_DATA_O[5] == $past(TIMER_OUT_O);
  endproperty
  a_out_bit: assert property (p_out_bit) else $error("output bit mismatch");

  property p_narrow_clear;
    tick && !wide && cnt_low == period_buf && !wr_low |=> cnt_low == 8'h00 && period_buf == $past(high_buf);
  endproperty
  a_narrow_clear: assert property (p_narrow_clear) else $error("narrow match no clear");

  property p_wide_wrap;
    tick && wide && {cnt_high, cnt_low} == 16'hFFFF && !wr_low |-> match ##1 {cnt_high, cnt_low} == 16'h0000;
  endproperty
  a_wide_wrap: assert property (p_wide_wrap) else $error("wide wrap missed");

  property p_post_clear;
    wr_a |=> post_cnt == 4'h0 && presc_cnt == 15'h0000;
  endproperty
  a_post_clear: assert property (p_post_clear) else $error("scalers not cleared");

  property p_presc_clear;
    wr_b || wr_low |=> presc_cnt == 15'h0000;
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared");

  property p_sleep_halt;
    SLEEP_I && !ctrl_b[4] && $stable(ADDR_I) && !WR_EN_I |=> $stable(cnt_low);
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("count moved in sync sleep");

  property p_disabled;
    !en |-> !div_evt ##1 !DIVIDED_MATCH_PULSE_O;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled timer produced event");

  property p_irq;
    wr_irq |=> TIMER_IRQ_O == ($past(WR_DATA_I[`TPIO_I_EN]) && irq_flag);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_div_one;
    match && div_sel == 4'h0 && !wr_low |-> div_evt;
  endproperty
  a_div_one: assert property (p_div_one) else $error("1:1 divider skipped event");

  c_div_evt: cover property (div_evt);
  c_wide_wrap: cover property (match && wide);
  c_async_sleep: cover property (SLEEP_I && ctrl_b[4] && tick);
  c_set_and_clear: cover property (div_evt && wr_irq);

endmodule : tpio_top

// file: logic/tpio_map.svh
// register offsets, field positions and reset values of the timer output stage
// assumes byte-wide registers on a plain strobe port with a 4-bit address
`ifndef TPIO_MAP_SVH
`define TPIO_MAP_SVH
// register offsets
`define TPIO_OFS_CTRL_A      4'h0
`define TPIO_OFS_CTRL_B      4'h1
`define TPIO_OFS_COUNT_LOW   4'h2
`define TPIO_OFS_COUNT_HIGH  4'h3
`define TPIO_OFS_IRQ         4'h4
// timer_control_a fields
`define TPIO_A_EN            7
`define TPIO_A_UNUSED        6
`define TPIO_A_OUT           5
`define TPIO_A_WIDE          4
`define TPIO_A_DIV_HI        3
// timer_control_b fields
`define TPIO_B_CS_HI         7
`define TPIO_B_CS_LO         5
`define TPIO_B_UNSYNC        4
`define TPIO_B_PS_HI         3
// interrupt register fields
`define TPIO_I_FLAG          0
`define TPIO_I_EN            1
// reset values, wide wrap value and source count
`define TPIO_RST_CTRL        8'h00
`define TPIO_RST_LOW         8'h00
`define TPIO_RST_HIGH        8'hFF
`define TPIO_WIDE_MAX        16'hFFFF
`define TPIO_NUM_SRC         5
`endif

// file: logic/tpio_pkg.sv
// types shared by the timer output stage
// assumes the offsets and fields come from tpio_map.svh
package tpio_pkg;
  // count clock selection, in field code order
  typedef enum logic [2:0] {
    SRC_PIN_TRUE,
    SRC_PIN_INV,
    SRC_INSTR,
    SRC_HIGH_OSC,
    SRC_LOW_OSC,
    SRC_MED_OSC,
    SRC_RESERVED,
    SRC_LOGIC_CELL
  } tpio_src_t;
endpackage : tpio_pkg

// file: dv/tpio_top_test.sv
// self-checking bench for the timer output stage: bus, scalers, output, flag, sleep
// assumes tpio_top with byte registers at offsets 0..4 and the flag register at 4
`timescale 1ns/1ps
module tpio_top_test;
  logic       clk   = 1'b0;
  logic       rst_n = 1'b0;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic       sleep = 1'b0;
  logic [3:0] addr  = 4'h0;
  logic [7:0] wdat  = 8'h00;
  logic [4:0] src   = 5'h00;
  logic [7:0] rdat;
  logic       tout, pulse, flag, irq, wake;
  int         fails = 0;
  int         n_checks = 0;
  int         seed = 65552;
  int         g, h;

  tpio_top dut (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WR_DATA_I(wdat), .WR_EN_I(wr), .RD_EN_I(rd),
    .RD_DATA_O(rdat), .COUNT_PIN_I(src[0]), .LOGIC_CELL_ONE_I(src[1]), .MEDIUM_INTERNAL_OSC_I(src[2]),
    .LOW_INTERNAL_OSC_I(src[3]), .HIGH_INTERNAL_OSC_I(src[4]), .SLEEP_I(sleep), .TIMER_OUT_O(tout),
    .DIVIDED_MATCH_PULSE_O(pulse), .TIMER_IRQ_FLAG_O(flag), .TIMER_IRQ_O(irq), .WAKE_O(wake)
  );

  // 10 MHz clock
  always #50 clk = ~clk;

  // random levels on every foreign clock source
  always @(posedge clk) begin
    src <= 5'($random(seed));
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // one-cycle write strobe
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr   <= 1'b0;
  endtask : wreg

  // one-cycle read strobe, data taken in the cycle after
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdat;
  endtask : rreg

  // cycles until the output level changes, bounded
  task automatic wait_tog(output int n);
    logic last;
    #1;
    last = tout;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (tout === last && n < 20000);
    // a stuck output counts as a mismatch, the run goes on to the verdict
    chk("toggle timeout", 16'(n >= 20000), 16'h0000);
  endtask : wait_tog

  // number of output changes over a span
  task automatic count_tog(input int span, output int n);
    logic last;
    n = 0;
    #1;
    last = tout;
    repeat (span) begin
      @(posedge clk);
      #1;
      if (tout !== last) n++;
      last = tout;
    end
  endtask : count_tog

  task automatic setup(input logic [7:0] cb, input logic [7:0] ca, input logic [7:0] per);
    wreg(4'h1, cb);
    wreg(4'h3, per);
    wreg(4'h2, 8'h00);
    wreg(4'h0, ca);
  endtask : setup

  // cycles between output changes: prescale times divider times period length
  function automatic int exp_gap(input int k, input int nd, input int p);
    return (1 << k) * (nd + 1) * (p + 1);
  endfunction : exp_gap

  // hang guard, well past the expected run of some 4000 cycles
  initial begin
    #6000000;
    fails++;
    wrap_up();
  end

  initial begin
    logic [7:0] d;
    logic [7:0] rst_exp [6];
    logic [3:0] k, nd, p;
    rst_exp = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values, unmapped places read zero
    for (int i = 0; i < 6; i++) begin
      rreg(4'(i), d);
      chk("reset value", 16'(d), 16'(rst_exp[i]));
    end
    rreg(4'hF, d);
    chk("unmapped", 16'(d), 16'h0000);
    wreg(4'h0, 8'h7F);
    rreg(4'h0, d);
    chk("ctrl_a fixed bits", 16'(d), 16'h001F);
    wreg(4'h1, 8'hFF);
    rreg(4'h1, d);
    chk("ctrl_b", 16'(d), 16'h00FF);
    $display("done registers");
    // divider, prescaler and period, corners first
    for (int i = 0; i < 10; i++) begin
      k  = (i < 2) ? 4'h0 : 4'($random(seed) & 3);
      nd = (i == 1) ? 4'hF : (i == 0) ? 4'h0 : 4'($random(seed));
      p  = (i == 0) ? 4'h0 : 4'($random(seed) & 7);
      setup({4'h4, k}, {4'h8, nd}, {4'h0, p});
      wait_tog(g);
      wait_tog(g);
      chk("gap", 16'(g), 16'(exp_gap(k, nd, p)));
      chk("flag", 16'(flag), 16'h0001);
      if (exp_gap(k, nd, p) > (1 << k) + 4) begin
        h = 0;
        while (pulse === 1'b1 && h < 40000) begin
          @(posedge clk);
          #1;
          h++;
        end
        chk("pulse width", 16'(h), 16'(1 << k));
        wreg(4'h4, 8'h00);
        #1;
        chk("flag clear", 16'(flag), 16'h0000);
      end
    end
    $display("done scalers");
    // repeated low writes keep the divider from completing
    setup(8'h40, 8'h83, 8'h03);
    wait_tog(g);
    g = 0;
    repeat (6) begin
      wreg(4'h2, 8'h00);
      count_tog(8, h);
      g += h;
    end
    chk("divider cleared", 16'(g), 16'h0000);
    $display("done divider clear");
    // sleep halts synchronised counting, unsynchronised keeps going and wakes
    setup(8'h40, 8'h80, 8'h01);
    wait_tog(g);
    @(posedge clk);
    sleep <= 1'b1;
    count_tog(3, h);
    count_tog(40, h);
    chk("sleep sync", 16'(h), 16'h0000);
    rreg(4'h0, d);
    chk("output bit", 16'(d[5]), 16'(tout));
    wreg(4'h4, 8'h02);
    wreg(4'h1, 8'h50);
    wait_tog(g);
    chk("wake", 16'({flag, irq, wake}), 16'h0007);
    @(posedge clk);
    sleep <= 1'b0;
    @(posedge clk);
    #1;
    chk("awake irq", 16'({irq, wake}), 16'h0002);
    wreg(4'h4, 8'h00);
    #1;
    chk("irq off", 16'(irq), 16'h0000);
    $display("done sleep");
    // every clock source code, reserved never counts
    for (int s = 0; s < 8; s++) begin
      setup({3'(s), 5'h00}, 8'h80, 8'h00);
      count_tog(80, h);
      chk("source active", 16'(h != 0), 16'(s != 6));
    end
    wreg(4'h0, 8'h00);
    count_tog(40, h);
    chk("disabled", 16'({h != 0, pulse}), 16'h0000);
    $display("done sources");
    // wide mode: buffered high byte, wrap past all ones
    wreg(4'h1, 8'h40);
    wreg(4'h0, 8'h10);
    wreg(4'h3, 8'h12);
    wreg(4'h2, 8'h34);
    rreg(4'h2, d);
    chk("wide low", 16'(d), 16'h0034);
    rreg(4'h3, d);
    chk("wide high", 16'(d), 16'h0012);
    wreg(4'h3, 8'hFF);
    wreg(4'h2, 8'hFC);
    wreg(4'h0, 8'h90);
    wait_tog(g);
    chk("wrap soon", 16'(g < 10), 16'h0001);
    rreg(4'h2, d);
    rreg(4'h3, d);
    chk("high after wrap", 16'(d), 16'h0000);
    $display("done wide mode");
    wrap_up();
  end
endmodule : tpio_top_test
